// ==== logic/oso_params.svh ====
// Constants of the octal serial output block
`ifndef OSO_PARAMS_SVH
`define OSO_PARAMS_SVH
`define OSO_LANES 8
`define OSO_WBITS 12
`define OSO_HALF 6
`define OSO_SLOT_W 4
`define OSO_LAST_SLOT 4'hb
`define OSO_PIPE_DEPTH 6
`define OSO_FIFO_DEPTH 8
`define OSO_BIT_DIV 2
`define OSO_CLK_MHZ 20
`define OSO_STOP_NS 300
`define OSO_STOP_CYC ((`OSO_STOP_NS * `OSO_CLK_MHZ + 999) / 1000)
`define OSO_RELOCK_US 10
`define OSO_RELOCK_CYC (`OSO_RELOCK_US * `OSO_CLK_MHZ)
`define OSO_CNT_W 9
`define OSO_DRIVE_DEFAULT 2'h0
`define OSO_DESKEW_WORD 12'haaa
`endif

// ==== logic/oso_pkg.sv ====
// Types of the octal serial output block
package oso_pkg;
    typedef enum logic [1:0] {OSO_SRC_DATA, OSO_SRC_CUSTOM, OSO_SRC_SYNC, OSO_SRC_DESKEW} oso_src_e;
    typedef enum logic [1:0] {OSO_LK_LOST, OSO_LK_WAIT, OSO_LK_LOCKED} oso_lock_e;
    typedef logic [95:0] oso_word_t;
endpackage

// ==== logic/oso_fifo.sv ====
// Word FIFO between the conversion pipeline and the serializer
`timescale 1ns/10ps
module oso_fifo #(
    parameter int W = 96,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rp_r];

    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (flush) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end else begin
            if (push) wp_nxt = AW'((wp_r + 1'b1) % D);
            if (pop) rp_nxt = AW'((rp_r + 1'b1) % D);
            cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            in_ready <= (cnt_nxt != (AW+1)'(D));
            out_valid <= (cnt_nxt != '0);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push && !flush) mem[wp_r] <= in_data;
    end
endmodule // oso_fifo

// ==== logic/oso_serializer.sv ====
// Octal serial lane output: pipeline, word FIFO, serializer, clocks, training patterns
// Contract
// - Shift each parallel word out serially
// - One full word per lane per frame
// - LSB first by default, MSB option
// - Bit clock toggles every bit slot
// - Frame clock marks twelve-bit word start
// - Deskew sends alternating zero-one bits
// - Sync sends six zeros, six ones
// - Custom pattern replaces conversion data
// - Power-down tri-states all output drivers
// - Four drive settings, first is default
// - Relock wait after short clock stop
// - Sample on sample clock rising edge
// - Six and a half cycle latency; pipeline pushes after five and a half
// - Reset zeros lanes, clocks keep toggling
// - Per-channel power-down from configuration
`timescale 1ns/10ps
`include "oso_params.svh"
module oso_serializer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Pins from outside the clock domain
    input wire logic sample_clock_in,
    input wire logic power_down_pin,
    input wire logic reset_pin,
    // Converter words, one 12-bit field per channel
    input wire oso_pkg::oso_word_t conv_data,
    // Configuration
    input wire logic cfg_msb_first,
    input wire logic cfg_deskew,
    input wire logic cfg_sync,
    input wire logic cfg_custom_en,
    input wire logic [`OSO_WBITS-1:0] cfg_custom_pattern,
    input wire logic [`OSO_LANES-1:0] cfg_chan_pd,
    input wire logic [1:0] cfg_drive_sel,
    // Serial lanes and clocks
    output logic [`OSO_LANES-1:0] lane_out,
    output logic [`OSO_LANES-1:0] lane_oe,
    output logic bit_clock_out,
    output logic frame_clock_out,
    output logic clock_oe,
    output logic [1:0] drive_current,
    // Status
    output logic data_valid,
    output logic word_dropped
);
    import oso_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] s1_r, s2_r;
    logic sck_d_r, sck_rise, sck_fall, pd_s, rstp_s;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            sck_d_r <= 1'b0;
        end else begin
            s1_r <= {reset_pin, power_down_pin, sample_clock_in};
            s2_r <= s1_r;
            sck_d_r <= s2_r[0];
        end
    end
    assign sck_rise = s2_r[0] && !sck_d_r;
    assign sck_fall = !s2_r[0] && sck_d_r;
    assign pd_s = s2_r[1];
    assign rstp_s = s2_r[2];

    // ----------------------------------------
    // Clock monitor and relock
    // ----------------------------------------
    oso_lock_e lk_r, lk_nxt;
    logic [`OSO_CNT_W-1:0] gap_r, gap_nxt, rel_r, rel_nxt;
    logic locked;

    always_comb begin
        lk_nxt = lk_r;
        gap_nxt = gap_r;
        rel_nxt = rel_r;
        if (sck_rise || sck_fall) begin
            gap_nxt = '0;
        end else if (gap_r != `OSO_CNT_W'(`OSO_STOP_CYC)) begin
            gap_nxt = gap_r + 1'b1;
        end
        case (lk_r)
            OSO_LK_LOST: begin
                if (sck_rise) begin
                    lk_nxt = OSO_LK_WAIT;
                    rel_nxt = '0;
                end
            end
            OSO_LK_WAIT: begin
                if (gap_r == `OSO_CNT_W'(`OSO_STOP_CYC)) begin
                    lk_nxt = OSO_LK_LOST;
                end else if (rel_r == `OSO_CNT_W'(`OSO_RELOCK_CYC - 1)) begin
                    lk_nxt = OSO_LK_LOCKED;
                end else begin
                    rel_nxt = rel_r + 1'b1;
                end
            end
            OSO_LK_LOCKED: begin
                if (gap_r == `OSO_CNT_W'(`OSO_STOP_CYC)) lk_nxt = OSO_LK_LOST;
            end
            default: lk_nxt = OSO_LK_LOST;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lk_r <= OSO_LK_LOST;
            gap_r <= '0;
            rel_r <= '0;
        end else begin
            lk_r <= lk_nxt;
            gap_r <= gap_nxt;
            rel_r <= rel_nxt;
        end
    end
    assign locked = (lk_r == OSO_LK_LOCKED);

    // ----------------------------------------
    // Conversion pipeline, five and a half periods
    // ----------------------------------------
    oso_word_t pipe_r [`OSO_PIPE_DEPTH];
    oso_word_t pipe_nxt [`OSO_PIPE_DEPTH];
    logic [`OSO_PIPE_DEPTH-1:0] pv_r, pv_nxt;
    logic push_pend_r, push_pend_nxt, fifo_in_ready, drop_nxt;
    logic fifo_push, fifo_out_valid, fifo_pop;
    oso_word_t fifo_out;

    // Six rising edges, push on falling
    always_comb begin
        pv_nxt = pv_r;
        push_pend_nxt = push_pend_r;
        for (int i = 0; i < `OSO_PIPE_DEPTH; i++) pipe_nxt[i] = pipe_r[i];
        if (rstp_s || pd_s) begin
            pv_nxt = '0;
            push_pend_nxt = 1'b0;
        end else if (sck_rise) begin
            pipe_nxt[0] = conv_data;
            for (int i = 1; i < `OSO_PIPE_DEPTH; i++) pipe_nxt[i] = pipe_r[i-1];
            pv_nxt = {pv_r[`OSO_PIPE_DEPTH-2:0], 1'b1};
            push_pend_nxt = pv_r[`OSO_PIPE_DEPTH-2];
        end else if (sck_fall) begin
            push_pend_nxt = 1'b0;
        end
    end
    assign fifo_push = sck_fall && push_pend_r && locked && !rstp_s && !pd_s;
    // A full FIFO cannot stall the converter, so the word is lost and flagged on word_dropped
    assign drop_nxt = fifo_push && !fifo_in_ready;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pv_r <= '0;
            push_pend_r <= 1'b0;
            word_dropped <= 1'b0;
        end else begin
            pv_r <= pv_nxt;
            push_pend_r <= push_pend_nxt;
            word_dropped <= drop_nxt;
        end
    end
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < `OSO_PIPE_DEPTH; i++) pipe_r[i] <= pipe_nxt[i];
    end

    oso_fifo #(
        .W($bits(oso_word_t)),
        .D(`OSO_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flush(rstp_s || pd_s),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(pipe_r[`OSO_PIPE_DEPTH-1]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    // ----------------------------------------
    // Serializer and frame timing
    // ----------------------------------------
    function automatic logic pick_bit(input logic [`OSO_WBITS-1:0] w,
                                      input logic [`OSO_SLOT_W-1:0] s, input logic msb);
        logic [`OSO_SLOT_W-1:0] idx;
        idx = msb ? (`OSO_LAST_SLOT - s) : s;
        pick_bit = w[idx];
    endfunction

    logic div_r, div_nxt, bit_en;
    logic [`OSO_SLOT_W-1:0] slot_r, slot_nxt;
    oso_word_t word_r, word_nxt;
    oso_src_e src;
    logic [`OSO_LANES-1:0] lane_nxt, oe_nxt;
    logic bck_nxt, fck_nxt, cke_nxt, frame_start, dv_nxt;
    logic [1:0] drv_nxt;

    // Bit slot rate from a divider of the system clock
    assign div_nxt = (div_r == 1'(`OSO_BIT_DIV - 1)) ? 1'b0 : div_r + 1'b1;
    assign bit_en = (div_r == 1'(`OSO_BIT_DIV - 1));
    assign frame_start = bit_en && (slot_r == `OSO_LAST_SLOT);
    assign fifo_pop = frame_start && fifo_out_valid;

    always_comb begin
        if (cfg_deskew) src = OSO_SRC_DESKEW;
        else if (cfg_sync) src = OSO_SRC_SYNC;
        else if (cfg_custom_en) src = OSO_SRC_CUSTOM;
        else src = OSO_SRC_DATA;
    end

    always_comb begin
        slot_nxt = slot_r;
        word_nxt = word_r;
        lane_nxt = lane_out;
        oe_nxt = lane_oe;
        bck_nxt = bit_clock_out;
        fck_nxt = frame_clock_out;
        cke_nxt = !pd_s;
        if (bit_en) begin
            slot_nxt = (slot_r == `OSO_LAST_SLOT) ? '0 : slot_r + 1'b1;
            // Load next word at frame edge
            if (frame_start) word_nxt = fifo_out_valid ? fifo_out : '0;
            // Bit clock, both edges carry bits
            bck_nxt = slot_r[0];
            // Frame clock high for first half
            fck_nxt = (slot_r < `OSO_SLOT_W'(`OSO_HALF));
            for (int l = 0; l < `OSO_LANES; l++) begin
                case (src)
                    OSO_SRC_DESKEW: lane_nxt[l] = pick_bit(`OSO_DESKEW_WORD, slot_r, 1'b0);
                    OSO_SRC_SYNC: lane_nxt[l] = (slot_r >= `OSO_SLOT_W'(`OSO_HALF));
                    OSO_SRC_CUSTOM: begin
                        lane_nxt[l] = pick_bit(cfg_custom_pattern, slot_r, cfg_msb_first);
                    end
                    OSO_SRC_DATA: begin
                        lane_nxt[l] = pick_bit(word_r[l*`OSO_WBITS +: `OSO_WBITS], slot_r,
                                               cfg_msb_first);
                    end
                    default: lane_nxt[l] = 1'b0;
                endcase
            end
        end
        // Zero code while reset pin active
        if (rstp_s) begin
            lane_nxt = '0;
            word_nxt = '0;
        end
        // Power-down releases every driver; per channel
        oe_nxt = pd_s ? '0 : ~cfg_chan_pd;
        lane_nxt = lane_nxt & oe_nxt;
        // Drive setting, cleared by reset pin
        drv_nxt = rstp_s ? `OSO_DRIVE_DEFAULT : cfg_drive_sel;
        dv_nxt = locked && !rstp_s && !pd_s;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 1'b0;
            slot_r <= '0;
            word_r <= '0;
            lane_out <= '0;
            lane_oe <= '0;
            bit_clock_out <= 1'b0;
            frame_clock_out <= 1'b0;
            clock_oe <= 1'b0;
            drive_current <= `OSO_DRIVE_DEFAULT;
            data_valid <= 1'b0;
        end else begin
            div_r <= div_nxt;
            slot_r <= slot_nxt;
            word_r <= word_nxt;
            lane_out <= lane_nxt;
            lane_oe <= oe_nxt;
            bit_clock_out <= bck_nxt;
            frame_clock_out <= fck_nxt;
            clock_oe <= cke_nxt;
            drive_current <= drv_nxt;
            data_valid <= dv_nxt;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    localparam int FCK_HIGH_CYC = `OSO_BIT_DIV * `OSO_HALF;

    a_bit_clock_toggle: assert property (bit_en |=> bit_clock_out == $past(slot_r[0]))
        else $error("bit clock out of step with slot");
    a_frame_clock_half: assert property (
        bit_en && slot_r == '0 |=> frame_clock_out ##FCK_HIGH_CYC !frame_clock_out)
        else $error("frame clock not high for half a frame");
    a_deskew_pattern: assert property (
        bit_en && cfg_deskew && !rstp_s && !pd_s && cfg_chan_pd == '0
        |=> lane_out == {`OSO_LANES{$past(slot_r[0])}})
        else $error("deskew lanes not alternating");
    a_sync_pattern: assert property (
        bit_en && !cfg_deskew && cfg_sync && !rstp_s && !pd_s && cfg_chan_pd == '0
        |=> lane_out == {`OSO_LANES{$past(slot_r) >= `OSO_SLOT_W'(`OSO_HALF)}})
        else $error("sync lanes wrong");
    a_pd_tristate: assert property (pd_s |=> lane_oe == '0 && !clock_oe && lane_out == '0)
        else $error("drivers on during power-down");
    a_chan_power: assert property (
        !pd_s |=> lane_oe == ~$past(cfg_chan_pd) && (lane_out & $past(cfg_chan_pd)) == '0)
        else $error("powered-down lane driven");
    a_reset_zero: assert property (rstp_s |=> lane_out == '0 && !data_valid)
        else $error("lanes not zero under reset pin");
    a_relock_wait: assert property (
        lk_r == OSO_LK_LOST ##1 lk_r == OSO_LK_WAIT |-> !locked [*8])
        else $error("lock claimed before relock wait");
    a_stop_unlock: assert property (
        locked && gap_r == `OSO_CNT_W'(`OSO_STOP_CYC) |=> !locked)
        else $error("clock stop not detected");
    a_drive_default: assert property (rstp_s |=> drive_current == `OSO_DRIVE_DEFAULT)
        else $error("drive setting not default");
    a_sample_rise: assert property (
        sck_rise && !rstp_s && !pd_s |=> pipe_r[0] == $past(conv_data))
        else $error("word not taken at sample rising edge");
    a_push_depth: assert property (
        fifo_push |-> pv_r == {`OSO_PIPE_DEPTH{1'b1}} && sck_fall)
        else $error("word pushed before six sample edges");

    c_frame_seen: cover property (frame_start && fifo_out_valid);
    c_msb_data: cover property (bit_en && src == OSO_SRC_DATA && cfg_msb_first && locked);
    c_relocked: cover property (lk_r == OSO_LK_WAIT ##1 lk_r == OSO_LK_LOCKED);
    c_word_drop: cover property (word_dropped);
endmodule // oso_serializer

// ==== testbench/oso_rx_model.sv ====
// Deserializer model at the far end of the serial lanes
`timescale 1ns/10ps
module oso_rx_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial side
    input wire logic [7:0] lane_out,
    input wire logic bit_clock_out,
    input wire logic frame_clock_out,
    input wire logic msb_first,
    // Reassembled words
    output logic [95:0] rx_word,
    output logic [15:0] rx_count,
    output logic [4:0] rx_toggles
);
    logic bc_q;
    logic fc_q;
    logic [3:0] slot;
    logic [3:0] s;
    logic [4:0] tog;
    logic [95:0] acc;
    logic [95:0] nxt;
    // ------------------------------
    // Capture on bit clock changes
    // ------------------------------
    // Bits read one cycle after the change, so the lane has settled
    // both edges, selected order
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bc_q <= 1'b0;
            fc_q <= 1'b0;
            slot <= 4'hc;
            tog <= 5'h0;
            acc <= '0;
            rx_word <= '0;
            rx_count <= 16'h0;
            rx_toggles <= 5'h0;
        end else begin
            bc_q <= bit_clock_out;
            fc_q <= frame_clock_out;
            if (bit_clock_out != bc_q) begin
                s = (frame_clock_out && !fc_q) ? 4'h0 : ((slot < 4'hc) ? slot + 4'h1 : slot);
                nxt = acc;
                if (s < 4'hc) begin
                    for (int l = 0; l < 8; l++) begin
                        nxt[l * 12 + (msb_first ? 11 - s : s)] = lane_out[l];
                    end
                end
                slot <= s;
                acc <= nxt;
                tog <= (s == 4'h0) ? 5'h1 : tog + 5'h1;
                if (s == 4'h0) begin
                    rx_toggles <= tog;
                end
                if (s == 4'hb) begin
                    rx_word <= nxt;
                    rx_count <= rx_count + 16'h1;
                end
            end
        end
    end
endmodule // oso_rx_model

// ==== testbench/oso_serializer_tb_top.sv ====
// Self-checking bench for the octal serial lane output block
`timescale 1ns/10ps
`include "oso_params.svh"
module oso_serializer_tb_top;
    import oso_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sample_clock_in = 1'b0;
    logic smp_run = 1'b1;
    logic power_down_pin = 1'b0;
    logic reset_pin = 1'b1;
    oso_word_t conv_data = '0;
    logic cfg_msb_first = 1'b0;
    logic cfg_deskew = 1'b1;
    logic cfg_sync = 1'b0;
    logic cfg_custom_en = 1'b0;
    logic [`OSO_WBITS-1:0] cfg_custom_pattern = 12'h5a3;
    logic [`OSO_LANES-1:0] cfg_chan_pd = 8'h00;
    logic [1:0] cfg_drive_sel = 2'h3;
    logic [`OSO_LANES-1:0] lane_out;
    logic [`OSO_LANES-1:0] lane_oe;
    logic bit_clock_out;
    logic frame_clock_out;
    logic clock_oe;
    logic [1:0] drive_current;
    logic data_valid;
    logic word_dropped;
    oso_word_t rx_word;
    logic [15:0] rx_count;
    logic [4:0] rx_toggles;
    int fails = 0;
    int n_checks = 0;
    int n;
    // Deskew, sync, custom, msb enables over the expected lane word
    localparam logic [15:0] PAT [5] = '{16'heaaa, 16'h9555, 16'h6fc0, 16'h25a3, 16'h35a3};
    // ------------------------------
    // Clocks
    // ------------------------------
    always #25 clk_sys = ~clk_sys;
    initial begin
        #13;
        forever begin
            #200;
            if (smp_run) sample_clock_in = ~sample_clock_in;
        end
    end
    // ------------------------------
    // Instances
    // ------------------------------
    oso_serializer DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .sample_clock_in(sample_clock_in),
        .power_down_pin(power_down_pin), .reset_pin(reset_pin), .conv_data(conv_data),
        .cfg_msb_first(cfg_msb_first), .cfg_deskew(cfg_deskew), .cfg_sync(cfg_sync),
        .cfg_custom_en(cfg_custom_en), .cfg_custom_pattern(cfg_custom_pattern),
        .cfg_chan_pd(cfg_chan_pd), .cfg_drive_sel(cfg_drive_sel), .lane_out(lane_out),
        .lane_oe(lane_oe), .bit_clock_out(bit_clock_out), .frame_clock_out(frame_clock_out),
        .clock_oe(clock_oe), .drive_current(drive_current), .data_valid(data_valid),
        .word_dropped(word_dropped)
    );
    oso_rx_model u_rx (
        .clk_sys(clk_sys), .rst_n(rst_n), .lane_out(lane_out), .bit_clock_out(bit_clock_out),
        .frame_clock_out(frame_clock_out), .msb_first(cfg_msb_first), .rx_word(rx_word),
        .rx_count(rx_count), .rx_toggles(rx_toggles)
    );
    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic close_out();
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk_word(input oso_word_t got, input oso_word_t exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for a count of whole received frames
    task automatic wait_frames(input int f);
        logic [15:0] start;
        int k;
        start = rx_count;
        k = 0;
        while (rx_count !== start + 16'(f) && k < 2000) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 2000) begin
            fails++;
            close_out();
        end
    endtask
    task automatic wait_dv(input logic lvl, input int bound, output int k);
        k = 0;
        while (data_valid !== lvl && k < bound) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= bound) begin
            fails++;
            close_out();
        end
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    initial begin
        for (int l = 0; l < 8; l++) begin
            conv_data[l * 12 +: 12] = 12'h801 + 12'(l) * 12'h110;
        end
        repeat (4) @(negedge clk_sys);
        chk_bits({lane_oe, lane_out}, 16'h0);
        rst_n = 1'b1;
        // Device reset pin held while deskew is asked for
        wait_frames(3);
        chk_word(rx_word, '0);
        chk_bits({11'h0, rx_toggles}, 16'h000c);
        chk_bits({14'h0, drive_current}, 16'h0);
        reset_pin = 1'b0;
        for (int i = 0; i < 5; i++) begin
            {cfg_deskew, cfg_sync, cfg_custom_en, cfg_msb_first} = PAT[i][15:12];
            wait_frames(2);
            chk_word(rx_word, {8{PAT[i][11:0]}});
        end
        for (int c = 0; c < 4; c++) begin
            cfg_drive_sel = 2'(c);
            repeat (2) @(negedge clk_sys);
            chk_bits({14'h0, drive_current}, 16'(c));
        end
        {cfg_deskew, cfg_sync, cfg_custom_en, cfg_msb_first} = 4'h0;
        wait_dv(1'b1, 400, n);
        wait_frames(3);
        chk_word(rx_word, conv_data);
        chk_bits({11'h0, rx_toggles}, 16'h000c);
        cfg_msb_first = 1'b1;
        wait_frames(2);
        chk_word(rx_word, conv_data);
        // Samples outpace frames, so the word FIFO has to refuse
        n = 0;
        while (word_dropped !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        chk_bits(16'(n < 200), 16'h1);
        // Sample clock stop, then relock
        smp_run = 1'b0;
        wait_dv(1'b0, 30, n);
        smp_run = 1'b1;
        wait_dv(1'b1, 400, n);
        chk_bits(16'(n >= 195 && n <= 230), 16'h1);
        wait_frames(3);
        chk_word(rx_word, conv_data);
        // New words must reach the lanes once the older ones have drained
        for (int l = 0; l < 8; l++) begin
            conv_data[l * 12 +: 12] = 12'h0c3 + 12'(l) * 12'h204;
        end
        wait_frames(14);
        chk_word(rx_word, conv_data);
        cfg_chan_pd = 8'h08;
        repeat (3) @(negedge clk_sys);
        chk_bits({8'h0, lane_oe}, 16'h00f7);
        power_down_pin = 1'b1;
        repeat (5) @(negedge clk_sys);
        chk_bits({lane_oe, lane_out}, 16'h0);
        chk_bits({14'h0, clock_oe, data_valid}, 16'h0);
        power_down_pin = 1'b0;
        cfg_chan_pd = 8'h00;
        repeat (5) @(negedge clk_sys);
        chk_bits({7'h0, clock_oe, lane_oe}, 16'h01ff);
        close_out();
    end
endmodule // oso_serializer_tb_top
